// file: hdl/tcm_timer8_compare.sv
// Counter, waveform-mode decode and compare-output latches for two channels.
// Assumes count_tick is a one-cycle timer-clock pulse synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module tcm_timer8_compare
    import tcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tcm_mode_type waveform_mode_select,
    input wire logic count_tick,
    input wire logic overflow_clear,
    input wire tcm_chan_in_type chan_a_in,
    input wire tcm_chan_in_type chan_b_in,
    output tcm_chan_out_type chan_a_out,
    output tcm_chan_out_type chan_b_out,
    output logic [7:0] count_value,
    output logic overflow_flag
);

    // ------------------------------------------------------------------
    // Latch update shared by both channels
    // ------------------------------------------------------------------
    function automatic logic latch_next(
        input logic latch,
        input tcm_action_type act,
        input logic is_a,
        input logic fast,
        input logic phase,
        input logic bit2,
        input logic match,
        input logic bottom_evt,
        input logic top_evt,
        input logic down,
        input logic eq_top,
        input logic force_cmp
    );
        logic nxt;
        nxt = latch;
        if (!fast && !phase) begin
            if (match || force_cmp) begin
                case (act)
                    TCM_ACT_TOGGLE: nxt = !latch;
                    TCM_ACT_CLEAR: nxt = 1'b0;
                    TCM_ACT_SET: nxt = 1'b1;
                    default: nxt = latch;
                endcase
            end
        end else if (act == TCM_ACT_TOGGLE) begin
            if (is_a && bit2 && match) begin
                nxt = !latch;
            end
        end else if (act[TCM_ACT_HIGH]) begin
            if (fast) begin
                if (match && !eq_top) begin
                    nxt = (act == TCM_ACT_SET);
                end
                if (bottom_evt) begin
                    nxt = (act == TCM_ACT_CLEAR);
                end
            end else begin
                if (match && !eq_top) begin
                    nxt = down ? (act == TCM_ACT_CLEAR) : (act == TCM_ACT_SET);
                end
                if (top_evt && eq_top) begin
                    nxt = (act == TCM_ACT_CLEAR);
                end
            end
        end
        return nxt;
    endfunction

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    tcm_state_type st_q;
    tcm_state_type st_d;
    logic fast;
    logic phase;
    logic immediate;
    logic bit2;
    logic [7:0] top_value;
    logic at_top;
    logic top_evt;
    logic wrap_evt;
    logic phase_bottom_evt;
    logic match_a;
    logic match_b;
    logic eq_top_a;
    logic eq_top_b;
    logic update_evt;
    logic ovf_set;

    assign bit2 = waveform_mode_select[TCM_MODE_BIT2];
    assign fast = (waveform_mode_select == TCM_MODE_FAST_MAX) ||
                  (waveform_mode_select == TCM_MODE_FAST_CMPA);
    assign phase = (waveform_mode_select == TCM_MODE_PHASE_MAX) ||
                   (waveform_mode_select == TCM_MODE_PHASE_CMPA);
    // Reserved codes fall back to immediate update, no PWM behaviour
    assign immediate = !fast && !phase;
    assign top_value = (bit2 || waveform_mode_select == TCM_MODE_CLEAR_ON_MATCH) ?
                       st_q.a.compare_value : TCM_MAX;
    assign at_top = (st_q.count_value == top_value);
    assign top_evt = count_tick && at_top && !st_q.count_down;
    assign wrap_evt = count_tick && at_top && !phase;
    assign phase_bottom_evt = count_tick && phase && st_q.count_down &&
                              (st_q.count_value == TCM_BOTTOM);
    assign match_a = count_tick && (st_q.count_value == st_q.a.compare_value);
    assign match_b = count_tick && (st_q.count_value == st_q.b.compare_value);
    assign eq_top_a = (st_q.a.compare_value == top_value);
    assign eq_top_b = (st_q.b.compare_value == top_value);
    // Mode 7 updates as the count wraps to BOTTOM, same tick as TOP
    assign update_evt = immediate || top_evt;

    always_comb begin
        case (waveform_mode_select)
            TCM_MODE_PHASE_MAX,
            TCM_MODE_PHASE_CMPA: ovf_set = phase_bottom_evt;
            TCM_MODE_FAST_CMPA: ovf_set = count_tick && at_top;
            default: ovf_set = count_tick && (st_q.count_value == TCM_MAX);
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (count_tick) begin
            if (!phase) begin
                st_d.count_down = 1'b0;
                st_d.count_value = at_top ? TCM_BOTTOM : st_q.count_value + TCM_ONE;
            end else if (!st_q.count_down) begin
                if (at_top) begin
                    st_d.count_down = 1'b1;
                    st_d.count_value = (st_q.count_value == TCM_BOTTOM) ?
                                       TCM_BOTTOM : st_q.count_value - TCM_ONE;
                end else begin
                    st_d.count_value = st_q.count_value + TCM_ONE;
                end
            end else if (st_q.count_value == TCM_BOTTOM) begin
                st_d.count_down = 1'b0;
                st_d.count_value = TCM_ONE;
            end else begin
                st_d.count_value = st_q.count_value - TCM_ONE;
            end
        end else if (!phase) begin
            st_d.count_down = 1'b0;
        end
        if (update_evt) begin
            st_d.a.compare_value = chan_a_in.compare_value;
            st_d.b.compare_value = chan_b_in.compare_value;
        end
        // Set wins over a clear in the same cycle
        st_d.overflow_flag = ovf_set || (st_q.overflow_flag && !overflow_clear);
        st_d.a.flag = match_a || (st_q.a.flag && !chan_a_in.compare_flag_clear);
        st_d.b.flag = match_b || (st_q.b.flag && !chan_b_in.compare_flag_clear);
        st_d.a.latch = latch_next(st_q.a.latch, chan_a_in.compare_output_action, 1'b1,
                                  fast, phase, bit2, match_a, wrap_evt, top_evt,
                                  st_q.count_down, eq_top_a,
                                  chan_a_in.force_compare_strobe);
        st_d.b.latch = latch_next(st_q.b.latch, chan_b_in.compare_output_action, 1'b0,
                                  fast, phase, bit2, match_b, wrap_evt, top_evt,
                                  st_q.count_down, eq_top_b,
                                  chan_b_in.force_compare_strobe);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and pin override
    // ------------------------------------------------------------------
    assign count_value = st_q.count_value;
    assign overflow_flag = st_q.overflow_flag;

    always_comb begin
        chan_a_out.compare_output_latch = st_q.a.latch;
        chan_a_out.compare_flag = st_q.a.flag;
        chan_a_out.pin_override = (chan_a_in.compare_output_action != TCM_ACT_OFF);
        chan_a_out.pin_value = chan_a_out.pin_override ? st_q.a.latch : chan_a_in.port_data;
        chan_a_out.pin_oe = chan_a_in.port_dir;
        chan_b_out.compare_output_latch = st_q.b.latch;
        chan_b_out.compare_flag = st_q.b.flag;
        chan_b_out.pin_override = (chan_b_in.compare_output_action != TCM_ACT_OFF);
        chan_b_out.pin_value = chan_b_out.pin_override ? st_q.b.latch : chan_b_in.port_data;
        chan_b_out.pin_oe = chan_b_in.port_dir;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_TOGGLE_NONPWM: assert property (
        (immediate && match_a && chan_a_in.compare_output_action == TCM_ACT_TOGGLE)
        |=> (st_q.a.latch != $past(st_q.a.latch))
    ) else $error("toggle on match missing");
    AST_FORCE_CLEAR: assert property (
        (immediate && chan_b_in.force_compare_strobe &&
         chan_b_in.compare_output_action == TCM_ACT_CLEAR) |=> !st_q.b.latch
    ) else $error("forced clear not applied");
    AST_FORCE_NO_FLAG: assert property (
        (chan_a_in.force_compare_strobe && !match_a && !chan_a_in.compare_flag_clear)
        |=> (st_q.a.flag == $past(st_q.a.flag))
    ) else $error("force changed compare flag");
    AST_FAST_NONINV_BOTTOM: assert property (
        (fast && wrap_evt && chan_a_in.compare_output_action == TCM_ACT_CLEAR)
        |=> st_q.a.latch && (st_q.count_value == TCM_BOTTOM)
    ) else $error("non-inverting not set at bottom");
    AST_FAST_INV_MATCH: assert property (
        (fast && match_b && !eq_top_b && !wrap_evt &&
         chan_b_in.compare_output_action == TCM_ACT_SET) |=> st_q.b.latch
    ) else $error("inverting not set on match");
    AST_PHASE_UP_CLEAR: assert property (
        (phase && match_a && !eq_top_a && !st_q.count_down &&
         chan_a_in.compare_output_action == TCM_ACT_CLEAR) |=> !st_q.a.latch
    ) else $error("phase up match did not clear");
    AST_PHASE_DOWN_CLEAR: assert property (
        (phase && match_b && !eq_top_b && st_q.count_down &&
         chan_b_in.compare_output_action == TCM_ACT_SET) |=> !st_q.b.latch
    ) else $error("phase down match did not clear");
    AST_FAST_TOP_IGNORE: assert property (
        (fast && match_a && eq_top_a && chan_a_in.compare_output_action == TCM_ACT_SET)
        |=> !st_q.a.latch
    ) else $error("match at top not ignored");
    AST_OVF_NORMAL: assert property (
        (waveform_mode_select == TCM_MODE_NORMAL && count_tick &&
         st_q.count_value == TCM_MAX) |=> overflow_flag && (count_value == TCM_BOTTOM)
    ) else $error("overflow not set at max");
    AST_B_RESERVED: assert property (
        ((fast || phase) && chan_b_in.compare_output_action == TCM_ACT_TOGGLE)
        |=> $stable(st_q.b.latch)
    ) else $error("channel b reserved action moved latch");
    AST_CLEAR_ON_MATCH_TOP: assert property (
        (waveform_mode_select == TCM_MODE_CLEAR_ON_MATCH && match_a)
        |=> (count_value == TCM_BOTTOM)
    ) else $error("clear on match did not restart");

endmodule
`default_nettype wire

// file: hdl/tcm_pkg.sv
// Constants and carrier types for the 8-bit timer compare-output block.
// Assumes one clock domain; all control bits arrive as plain ports.
package tcm_pkg;

    localparam logic [7:0] TCM_MAX = 8'hff;
    localparam logic [7:0] TCM_BOTTOM = 8'h00;
    localparam logic [7:0] TCM_ONE = 8'h01;
    localparam int TCM_MODE_BIT2 = 2;
    localparam int TCM_ACT_HIGH = 1;

    typedef enum logic [2:0] {
        TCM_MODE_NORMAL = 3'b000,
        TCM_MODE_PHASE_MAX = 3'b001,
        TCM_MODE_CLEAR_ON_MATCH = 3'b010,
        TCM_MODE_FAST_MAX = 3'b011,
        TCM_MODE_RSVD4 = 3'b100,
        TCM_MODE_PHASE_CMPA = 3'b101,
        TCM_MODE_RSVD6 = 3'b110,
        TCM_MODE_FAST_CMPA = 3'b111
    } tcm_mode_type;

    typedef enum logic [1:0] {
        TCM_ACT_OFF = 2'b00,
        TCM_ACT_TOGGLE = 2'b01,
        TCM_ACT_CLEAR = 2'b10,
        TCM_ACT_SET = 2'b11
    } tcm_action_type;

    typedef struct packed {
        tcm_action_type compare_output_action;
        logic force_compare_strobe;
        logic [7:0] compare_value;
        logic compare_flag_clear;
        logic port_data;
        logic port_dir;
    } tcm_chan_in_type;

    typedef struct packed {
        logic compare_output_latch;
        logic pin_override;
        logic pin_value;
        logic pin_oe;
        logic compare_flag;
    } tcm_chan_out_type;

    typedef struct packed {
        logic [7:0] compare_value;
        logic latch;
        logic flag;
    } tcm_chan_state_type;

    typedef struct packed {
        logic [7:0] count_value;
        logic count_down;
        logic overflow_flag;
        tcm_chan_state_type a;
        tcm_chan_state_type b;
    } tcm_state_type;

endpackage

// file: tb/tcm_pin_load.sv
// Pin and external load model for one compare-output channel.
// Assumes pin_value and pin_oe come straight from the timer block.
`timescale 1ns/10ps
`default_nettype none
module tcm_pin_load #(
    parameter logic PULL_LEVEL = 1'b1
) (
    input wire logic pin_value,
    input wire logic pin_oe,
    output logic pad
);
    // Released pad goes to the pull level, never keeps the old value
    assign pad = pin_oe ? pin_value : PULL_LEVEL;
endmodule
`default_nettype wire

// file: tb/tcm_timer8_compare_test.sv
// Self-checking bench for the timer compare block with pin loads.
// Assumes a 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tcm_timer8_compare_test
    import tcm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    tcm_mode_type mode = TCM_MODE_NORMAL;
    logic tick = 1'b0;
    logic ovc = 1'b0;
    tcm_chan_in_type ia = '0;
    tcm_chan_in_type ib = '0;
    tcm_chan_out_type oa;
    tcm_chan_out_type ob;
    logic [7:0] cnt;
    logic ovf;
    logic pad_a;
    logic pad_b;
    int err_count = 0;
    int n_tests = 0;

    always #2 sys_clk = ~sys_clk;

    tcm_timer8_compare u_tcm_timer8_compare (.sys_clk(sys_clk), .rst_n(rst_n),
        .waveform_mode_select(mode), .count_tick(tick), .overflow_clear(ovc),
        .chan_a_in(ia), .chan_b_in(ib), .chan_a_out(oa), .chan_b_out(ob),
        .count_value(cnt), .overflow_flag(ovf));
    tcm_pin_load u_tcm_pin_load (.pin_value(oa.pin_value), .pin_oe(oa.pin_oe), .pad(pad_a));
    tcm_pin_load u_tcm_pin_load_b (.pin_value(ob.pin_value), .pin_oe(ob.pin_oe), .pad(pad_b));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compares load in mode 0, so every scenario starts from known values
    task automatic restart(input logic [7:0] ca, input logic [7:0] cb);
        @(negedge sys_clk);
        rst_n = 1'b0;
        mode = TCM_MODE_NORMAL;
        ia = '0;
        ib = '0;
        ia.compare_value = ca;
        ib.compare_value = cb;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk(oa.compare_output_latch, 0);
    endtask

    task automatic tick_n(input int n);
        tick = 1'b1;
        repeat (n) @(negedge sys_clk);
        tick = 1'b0;
    endtask

    task automatic tick_to(input logic [7:0] v);
        int i;
        tick = 1'b1;
        for (i = 0; i < 600 && cnt !== v; i++) begin
            @(negedge sys_clk);
        end
        tick = 1'b0;
        chk(cnt, v);
    endtask

    task automatic force_a(input tcm_action_type act, input logic exp);
        ia.compare_output_action = act;
        ia.force_compare_strobe = 1'b1;
        @(negedge sys_clk);
        ia.force_compare_strobe = 1'b0;
        @(negedge sys_clk);
        chk(oa.compare_output_latch, exp);
        chk(oa.compare_flag, 0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_force();
        restart(8'h10, 8'h10);
        ia.port_data = 1'b1;
        ia.port_dir = 1'b1;
        force_a(TCM_ACT_SET, 1);
        force_a(TCM_ACT_CLEAR, 0);
        chk(pad_a, 0);
        // Channel B forced twice back to back, pin driven from the latch
        ib.port_data = 1'b1;
        ib.port_dir = 1'b1;
        ib.compare_output_action = TCM_ACT_SET;
        ib.force_compare_strobe = 1'b1;
        @(negedge sys_clk);
        chk(ob.compare_output_latch, 1);
        ib.compare_output_action = TCM_ACT_CLEAR;
        @(negedge sys_clk);
        ib.force_compare_strobe = 1'b0;
        chk(ob.compare_output_latch, 0);
        chk(pad_b, 0);
        force_a(TCM_ACT_TOGGLE, 1);
        chk(cnt, 0);
        ia.port_dir = 1'b0;
        // Port data differs from the latch, so release of the override is visible
        ia.port_data = 1'b0;
        force_a(TCM_ACT_OFF, 1);
        chk(pad_a, 1);
        chk(oa.pin_value, 0);
        chk(oa.pin_override, 0);
    endtask

    task automatic t_match();
        restart(8'h03, 8'h02);
        force_a(TCM_ACT_SET, 1);
        ia.compare_output_action = TCM_ACT_CLEAR;
        ib.compare_output_action = TCM_ACT_TOGGLE;
        tick_n(2);
        chk(oa.compare_output_latch, 1);
        tick_n(2);
        chk(oa.compare_output_latch, 0);
        chk(oa.compare_flag, 1);
        chk(ob.compare_output_latch, 1);
        chk(ob.compare_flag, 1);
        chk(ob.pin_value, 1);
        // Immediate compare update, then a toggle on the new match
        ia.compare_value = 8'h06;
        ia.compare_output_action = TCM_ACT_TOGGLE;
        tick_n(3);
        chk(oa.compare_output_latch, 1);
        tick_to(8'h00);
        chk(ovf, 1);
    endtask

    task automatic t_fast();
        restart(8'h02, 8'h02);
        force_a(TCM_ACT_SET, 1);
        mode = TCM_MODE_FAST_MAX;
        ia.compare_output_action = TCM_ACT_CLEAR;
        ib.compare_output_action = TCM_ACT_SET;
        tick_to(8'h03);
        chk(oa.compare_output_latch, 0);
        chk(ob.compare_output_latch, 1);
        tick_to(8'h00);
        chk(oa.compare_output_latch, 1);
        chk(ob.compare_output_latch, 0);
        chk(ovf, 1);
        ovc = 1'b1;
        @(negedge sys_clk);
        ovc = 1'b0;
        chk(ovf, 0);
    endtask

    task automatic t_phase();
        restart(8'h04, 8'h04);
        force_a(TCM_ACT_SET, 1);
        mode = TCM_MODE_PHASE_MAX;
        ia.compare_output_action = TCM_ACT_CLEAR;
        ib.compare_output_action = TCM_ACT_SET;
        tick_to(8'h05);
        chk(oa.compare_output_latch, 0);
        chk(ob.compare_output_latch, 1);
        tick_to(8'hff);
        tick_to(8'h03);
        chk(oa.compare_output_latch, 1);
        chk(ob.compare_output_latch, 0);
        chk(ovf, 0);
        tick_to(8'h00);
        tick_n(1);
        chk(cnt, 1);
        chk(ovf, 1);
    endtask

    task automatic t_top(input tcm_mode_type m);
        restart(8'hff, 8'hff);
        // A starts high so its clear at the end is visible
        force_a(TCM_ACT_SET, 1);
        mode = m;
        ib.compare_output_action = TCM_ACT_CLEAR;
        tick_to(8'hff);
        tick_n(1);
        chk(oa.compare_output_latch, 0);
        chk(ob.compare_output_latch, 1);
    endtask

    task automatic t_toggle();
        restart(8'h03, 8'h01);
        mode = TCM_MODE_FAST_CMPA;
        ia.compare_output_action = TCM_ACT_TOGGLE;
        ib.compare_output_action = TCM_ACT_TOGGLE;
        tick_to(8'h03);
        chk(ob.compare_output_latch, 0);
        tick_n(1);
        chk(cnt, 0);
        chk(oa.compare_output_latch, 1);
        mode = TCM_MODE_FAST_MAX;
        tick_to(8'h04);
        chk(oa.compare_output_latch, 1);
    endtask

    // Reserved codes 100 and 110 are never driven
    task automatic t_modes();
        tcm_mode_type m[6];
        logic [7:0] c[6];
        logic o[6];
        m = '{TCM_MODE_NORMAL, TCM_MODE_PHASE_MAX, TCM_MODE_CLEAR_ON_MATCH,
              TCM_MODE_FAST_MAX, TCM_MODE_PHASE_CMPA, TCM_MODE_FAST_CMPA};
        c = '{8'h06, 8'h06, 8'h00, 8'h06, 8'h04, 8'h00};
        o = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        for (int k = 0; k < 6; k++) begin
            restart(8'h05, 8'h05);
            mode = m[k];
            ia.compare_output_action = tcm_action_type'(k % 4);
            tick_n(6);
            chk(cnt, c[k]);
            chk(ovf, o[k]);
        end
    endtask

    initial begin
        t_force();
        t_match();
        t_fast();
        t_phase();
        t_top(TCM_MODE_FAST_MAX);
        t_top(TCM_MODE_PHASE_MAX);
        t_toggle();
        t_modes();
        wrap_up();
    end

    // Whole run needs about 1700 cycles; this allows over ten times that
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
